// ### design/tpc_top.sv
/*
 * tuner synthesiser front end control: oscillator input select and
 * gating, tri-state charge pump drive, shared counter pin control, apb
 * register file.
 * assumes backup and halt indications come from logic on pclk, and
 * that the oscillator, divider, reference and counter pins are async.
 */
`timescale 1ns/1ps
`include "tpc_defs.svh"

module tpc_top
    import tpc_pkg::*;
#(
    parameter int unsigned GATE_SHORT_CYC =
        `TPC_GATE_SHORT_MS * (`TPC_CLK_HZ / 1000), // 8 ms gate
    parameter int unsigned GATE_LONG_CYC  =
        `TPC_GATE_LONG_MS * (`TPC_CLK_HZ / 1000),  // 32 ms gate
    parameter int CNT_W = 20                        // count width
)
(
    input  wire logic        pclk,                 // machine clock
    input  wire logic        presetn,              // async reset, low
    input  wire logic        psel,                 // apb select
    input  wire logic        penable,              // apb enable
    input  wire logic        pwrite,               // apb write
    input  wire logic [11:0] paddr,                // apb address
    input  wire logic [31:0] pwdata,               // apb write data
    output logic      [31:0] prdata,               // apb read data
    output logic             pready,               // apb ready
    output logic             pslverr,              // apb error
    input  wire logic        backup_mode,          // system backup
    input  wire logic        halt_mode,            // system halt
    input  wire logic        fm_osc_input,         // fm oscillator pin
    input  wire logic        am_osc_input,         // am oscillator pin
    input  wire logic        div_feedback,         // divided osc pin
    input  wire logic        ref_clk_in,           // reference pin
    input  wire logic        shared_counter_input, // shared pin
    output logic             divider_input,        // to divider
    output logic             fm_in_enable,         // fm amp on
    output logic             am_in_enable,         // am amp on
    output logic             am_low_band,          // am low band
    output logic             charge_pump_output,   // pump level
    output logic             charge_pump_oe        // pump driven
);

    localparam int GATE_W = 24;

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]  pll_input_select_word_r; // oscillator select
    logic        pll_stop_r;              // synthesiser stop
    logic        port_function_instr_r;   // 1: counter input
    logic [3:0]  counter_setup_instr_r;   // mode and gate code
    logic        counter_start_instr_r;   // start pulse
    logic [31:0] prdata_r;                // read data
    logic        fm_en_r;                 // fm path enabled
    logic        am_en_r;                 // am path enabled
    logic        am_low_r;                // am low band
    logic [2:0]  sync1_r;                 // first sync stage
    logic [2:0]  sync2_r;                 // second sync stage
    logic [2:0]  dly_r;                   // edge detect delay
    tpc_cp_type  cp_state_r;              // pump state
    tpc_cp_type  cp_state_nxt;            // next pump state

    wire         pll_active;    // synthesiser allowed to run
    wire         div_rise;      // divided osc edge
    wire         ref_rise;      // reference edge
    wire         pin_rise;      // shared pin edge
    wire         pin_level;     // shared pin level
    wire         wr_en;         // write access phase
    wire         rd_setup;      // read setup phase
    wire         addr_hit;      // mapped address
    wire         setup_ok;      // frequency mode, listed gate
    wire [GATE_W-1:0] gate_sel; // selected gate length
    wire [31:0]  rd_mux;        // read selection
    wire [CNT_W-1:0] count_w;   // counter value
    wire         busy_w;        // gate open
    wire         done_w;        // count frozen

    tpc_cnt_if #(.CNT_W(CNT_W), .GATE_W(GATE_W)) cnt_bus ();

    // address compare shared by write strobes and read mux
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb slave

    // zero wait states: the answer is ready in the access phase
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_hit = hit(paddr, `TPC_OFF_INSEL)
                   || hit(paddr, `TPC_OFF_STOP)
                   || hit(paddr, `TPC_OFF_PORTFN)
                   || hit(paddr, `TPC_OFF_SETUP)
                   || hit(paddr, `TPC_OFF_START)
                   || hit(paddr, `TPC_OFF_STATUS)
                   || hit(paddr, `TPC_OFF_COUNT);
    assign pslverr  = psel && penable && !addr_hit;

    // start reads back zero; it only makes a pulse
    assign rd_mux =
        hit(paddr, `TPC_OFF_INSEL)  ? {30'h0, pll_input_select_word_r} :
        hit(paddr, `TPC_OFF_STOP)   ? {31'h0, pll_stop_r} :
        hit(paddr, `TPC_OFF_PORTFN) ? {31'h0, port_function_instr_r} :
        hit(paddr, `TPC_OFF_SETUP)  ? {28'h0, counter_setup_instr_r} :
        hit(paddr, `TPC_OFF_STATUS) ? {28'h0, pin_level, pll_active,
                                       done_w, busy_w} :
        hit(paddr, `TPC_OFF_COUNT)  ? {{(32-CNT_W){1'b0}}, count_w} :
                                      32'h0000_0000;

    // read data captured in the setup phase, held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (rd_setup)
            prdata_r <= rd_mux;
    end
    assign prdata = prdata_r;

    // writable control registers; stop resets set so inputs start off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_input_select_word_r <= `TPC_RST_INSEL;
            pll_stop_r              <= `TPC_RST_STOP;
            port_function_instr_r   <= `TPC_RST_PORTFN;
            counter_setup_instr_r   <= `TPC_RST_SETUP;
        end
        else if (wr_en)
        begin
            if (hit(paddr, `TPC_OFF_INSEL))
                pll_input_select_word_r <= pwdata[1:0];
            if (hit(paddr, `TPC_OFF_STOP))
                pll_stop_r <= pwdata[0];
            if (hit(paddr, `TPC_OFF_PORTFN))
                port_function_instr_r <= pwdata[0];
            if (hit(paddr, `TPC_OFF_SETUP))
                counter_setup_instr_r <= pwdata[3:0];
        end
    end

    // start command is a one-cycle pulse, writing bit 0 high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            counter_start_instr_r <= 1'b0;
        else
            counter_start_instr_r <= wr_en && pwdata[0]
                                     && hit(paddr, `TPC_OFF_START);
    end

    ////////////////////////////////////////////////////////////////////
    // oscillator input selection

    // reset is covered by the stop bit resetting high
    assign pll_active = !backup_mode && !halt_mode && !pll_stop_r;

    // amplifier enables registered; reserved code 3 enables nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fm_en_r  <= 1'b0;
            am_en_r  <= 1'b0;
            am_low_r <= 1'b0;
        end
        else
        begin
            fm_en_r  <= pll_active && pll_input_select_word_r
                        == `TPC_SEL_FM;
            am_en_r  <= pll_active && (pll_input_select_word_r
                        == `TPC_SEL_AM_HI || pll_input_select_word_r
                        == `TPC_SEL_AM_LO);
            am_low_r <= pll_input_select_word_r == `TPC_SEL_AM_LO;
        end
    end

    // oscillator path is a plain gate: it is far faster than pclk and
    // must never be sampled
    assign divider_input = (fm_en_r && fm_osc_input)
                        || (am_en_r && am_osc_input);
    assign fm_in_enable  = fm_en_r;
    assign am_in_enable  = am_en_r;
    assign am_low_band   = am_low_r;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: divider, reference, shared pin

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            dly_r   <= 3'h0;
        end
        else
        begin
            sync1_r <= {shared_counter_input, ref_clk_in, div_feedback};
            sync2_r <= sync1_r;
            dly_r   <= sync2_r;
        end
    end

    assign div_rise  = sync2_r[0] && !dly_r[0];
    assign ref_rise  = sync2_r[1] && !dly_r[1];
    assign pin_rise  = sync2_r[2] && !dly_r[2];
    assign pin_level = sync2_r[2];

    ////////////////////////////////////////////////////////////////////
    // charge pump comparator

    // an edge that leads pushes the pump; the lagging edge releases it.
    // limitation: edges are resolved only to one pclk period
    always_comb
    begin
        cp_state_nxt = cp_state_r;
        if (!pll_active)
            cp_state_nxt = TPC_CP_Z;
        else if (div_rise && ref_rise)
            cp_state_nxt = TPC_CP_Z;
        else if (div_rise)
        begin
            case (cp_state_r)
                TPC_CP_DN: cp_state_nxt = TPC_CP_Z;
                default:   cp_state_nxt = TPC_CP_UP;
            endcase
        end
        else if (ref_rise)
        begin
            case (cp_state_r)
                TPC_CP_UP: cp_state_nxt = TPC_CP_Z;
                default:   cp_state_nxt = TPC_CP_DN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cp_state_r <= TPC_CP_Z;
        else
            cp_state_r <= cp_state_nxt;
    end

    assign charge_pump_output = cp_state_r[1];
    assign charge_pump_oe     = !cp_state_r[0];

    ////////////////////////////////////////////////////////////////////
    // universal counter control

    // reserved mode or gate codes leave the start without effect
    assign setup_ok = counter_setup_instr_r[3:2] == `TPC_MODE_FREQ
                   && counter_setup_instr_r[1];
    assign gate_sel = (counter_setup_instr_r[1:0] == `TPC_GATE_LONG)
                    ? GATE_W'(GATE_LONG_CYC)
                    : GATE_W'(GATE_SHORT_CYC);

    assign cnt_bus.start    = counter_start_instr_r && setup_ok;
    assign cnt_bus.gate_cyc = gate_sel;
    assign cnt_bus.count_en = port_function_instr_r;
    assign cnt_bus.pin_rise = pin_rise;
    assign busy_w  = cnt_bus.busy;
    assign done_w  = cnt_bus.done;
    assign count_w = cnt_bus.count;

    tpc_counter #(.CNT_W(CNT_W), .GATE_W(GATE_W)) u_counter
    (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (cnt_bus.cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_div_lead;
        pll_active && div_rise && !ref_rise && cp_state_r != TPC_CP_DN;
    endsequence

    sequence s_ref_lead;
        pll_active && ref_rise && !div_rise && cp_state_r != TPC_CP_UP;
    endsequence

    property p_fm_route;
        @(posedge pclk) disable iff (!presetn)
        fm_en_r |-> $past(pll_input_select_word_r) == `TPC_SEL_FM
                    && $past(pll_active);
    endproperty
    a_fm_route: assert property (p_fm_route)
        else $error("fm path open without fm select");

    property p_inputs_off;
        @(posedge pclk) disable iff (!presetn)
        !pll_active |=> !fm_en_r && !am_en_r && !divider_input;
    endproperty
    a_inputs_off: assert property (p_inputs_off)
        else $error("oscillator input open while stopped");

    property p_am_band;
        @(posedge pclk) disable iff (!presetn)
        am_en_r |-> am_low_band
            == ($past(pll_input_select_word_r) == `TPC_SEL_AM_LO);
    endproperty
    a_am_band: assert property (p_am_band)
        else $error("am band differs from select code");

    property p_start_gated;
        @(posedge pclk) disable iff (!presetn)
        $rose(busy_w) |-> $past(counter_start_instr_r)
            && $past(counter_setup_instr_r[3:2]) == `TPC_MODE_FREQ;
    endproperty
    a_start_gated: assert property (p_start_gated)
        else $error("count began without a valid start");

    property p_pump_high;
        @(posedge pclk) disable iff (!presetn)
        s_div_lead |=> charge_pump_oe && charge_pump_output;
    endproperty
    a_pump_high: assert property (p_pump_high)
        else $error("pump not high with divided frequency leading");

    property p_pump_low;
        @(posedge pclk) disable iff (!presetn)
        s_ref_lead |=> charge_pump_oe && !charge_pump_output;
    endproperty
    a_pump_low: assert property (p_pump_low)
        else $error("pump not low with reference leading");

    property p_pump_match;
        @(posedge pclk) disable iff (!presetn)
        (pll_active && div_rise && ref_rise) |=> !charge_pump_oe;
    endproperty
    a_pump_match: assert property (p_pump_match)
        else $error("pump driven on matching edges");

    property p_pump_off;
        @(posedge pclk) disable iff (!presetn)
        !pll_active [*2] |-> !charge_pump_oe;
    endproperty
    a_pump_off: assert property (p_pump_off)
        else $error("pump driven while synthesiser stopped");

endmodule

// ### design/tpc_defs.svh
/*
 * constants for the tuner synthesiser input and counter control block:
 * register offsets, field codes, reset values and gate timing.
 * assumes it is included by bare name wherever these values are used.
 */
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// register byte offsets on the apb bus
`define TPC_OFF_INSEL   12'h000
`define TPC_OFF_STOP    12'h004
`define TPC_OFF_PORTFN  12'h008
`define TPC_OFF_SETUP   12'h00C
`define TPC_OFF_START   12'h010
`define TPC_OFF_STATUS  12'h014
`define TPC_OFF_COUNT   12'h018

// input select word, bits 1:0
`define TPC_SEL_FM      2'h0
`define TPC_SEL_AM_HI   2'h1
`define TPC_SEL_AM_LO   2'h2

// counter setup word: mode in bits 3:2, gate time in bits 1:0
`define TPC_MODE_FREQ   2'h0
`define TPC_GATE_SHORT  2'h2
`define TPC_GATE_LONG   2'h3

// status register bit positions
`define TPC_ST_BUSY     0
`define TPC_ST_DONE     1
`define TPC_ST_ACTIVE   2
`define TPC_ST_GPIN     3

// reset values
`define TPC_RST_INSEL   2'h0
`define TPC_RST_STOP    1'h1
`define TPC_RST_PORTFN  1'h0
`define TPC_RST_SETUP   4'h0

// timing
`define TPC_CLK_HZ        10000000
`define TPC_GATE_SHORT_MS 8
`define TPC_GATE_LONG_MS  32

`endif

// ### design/tpc_pkg.sv
/*
 * types shared by the tuner synthesiser control block.
 * assumes nothing beyond a sv compiler.
 */
package tpc_pkg;

    // charge pump drive state, one-hot
    typedef enum logic [2:0]
    {
        TPC_CP_Z  = 3'b001,
        TPC_CP_UP = 3'b010,
        TPC_CP_DN = 3'b100
    } tpc_cp_type;

    // gate counter state, one-hot
    typedef enum logic [2:0]
    {
        TPC_CNT_IDLE = 3'b001,
        TPC_CNT_GATE = 3'b010,
        TPC_CNT_DONE = 3'b100
    } tpc_cnt_state_type;

endpackage

// ### design/tpc_cnt_if.sv
/*
 * link between the control top and the gate counter.
 * assumes both ends run on pclk.
 */
`timescale 1ns/1ps

interface tpc_cnt_if #(parameter int CNT_W = 20, parameter int GATE_W = 24);
    logic              start;     // one-cycle start request
    logic [GATE_W-1:0] gate_cyc;  // gate length in cycles
    logic              count_en;  // pin acts as counter input
    logic              pin_rise;  // synced rising edge of pin
    logic              busy;      // gate open
    logic              done;      // count frozen
    logic [CNT_W-1:0]  count;     // counted edges

    modport ctl (output start, gate_cyc, count_en, pin_rise,
                 input busy, done, count);
    modport cnt (input start, gate_cyc, count_en, pin_rise,
                 output busy, done, count);
endinterface

// ### design/tpc_counter.sv
/*
 * gate-time counter for the shared counter pin.
 * assumes a synced edge pulse and a validated start pulse from the top.
 */
`timescale 1ns/1ps

module tpc_counter
    import tpc_pkg::*;
#(
    parameter int CNT_W  = 20,  // count width
    parameter int GATE_W = 24   // gate length width
)
(
    input  wire logic  pclk,    // machine clock
    input  wire logic  presetn, // async reset, low
    tpc_cnt_if.cnt     bus      // link to the top
);

    tpc_cnt_state_type  state_r;     // gate state
    tpc_cnt_state_type  state_nxt;   // next gate state
    logic [GATE_W-1:0]  left_r;      // cycles left in gate
    logic [CNT_W-1:0]   count_r;     // edge count
    logic [GATE_W-1:0]  run_len_r;   // helper: cycles spent gated
    logic [GATE_W-1:0]  gate_len_r;  // helper: gate length taken

    ////////////////////////////////////////////////////////////////////
    // next state

    // a start in any state reopens the gate and clears the count
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            TPC_CNT_IDLE: if (bus.start) state_nxt = TPC_CNT_GATE;
            TPC_CNT_GATE: if (!bus.start && left_r == '0)
                              state_nxt = TPC_CNT_DONE;
            TPC_CNT_DONE: if (bus.start) state_nxt = TPC_CNT_GATE;
            default:      state_nxt = TPC_CNT_IDLE;
        endcase
    end

    // state and gate timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= TPC_CNT_IDLE;
            left_r  <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            if (bus.start)
                left_r <= bus.gate_cyc - GATE_W'(1);
            else if (state_r == TPC_CNT_GATE && left_r != '0)
                left_r <= left_r - GATE_W'(1);
        end
    end

    // edges counted only while gated and in counter function
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= '0;
        else if (bus.start)
            count_r <= '0;
        else if (state_r == TPC_CNT_GATE && bus.count_en && bus.pin_rise)
            count_r <= count_r + CNT_W'(1);
    end

    assign bus.busy  = state_r[1];
    assign bus.done  = state_r[2];
    assign bus.count = count_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    // helper: measure how long the gate really stayed open
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_len_r  <= '0;
            gate_len_r <= '0;
        end
        else if (bus.start)
        begin
            run_len_r  <= '0;
            gate_len_r <= bus.gate_cyc;
        end
        else if (state_r == TPC_CNT_GATE)
            run_len_r <= run_len_r + GATE_W'(1);
    end

    property p_gate_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(bus.done) |-> run_len_r == gate_len_r;
    endproperty
    a_gate_len: assert property (p_gate_len)
        else $error("gate length differs from selected time");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        (bus.done && !bus.start) |=> $stable(bus.count);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("count moved after the gate closed");

    property p_no_count_gp;
        @(posedge pclk) disable iff (!presetn)
        (!bus.count_en && !bus.start) |=> $stable(bus.count);
    endproperty
    a_no_count_gp: assert property (p_no_count_gp)
        else $error("count moved while pin is a general input");

endmodule

// ### test/tpc_osc_model.sv
/* oscillator, divider and reference model for the synthesiser front end.
   assumes one pclk and half periods set by the bench. */
`timescale 1ns/1ps

module tpc_osc_model
(
    input  wire logic       pclk,   // machine clock
    input  wire logic [7:0] div_h,  // divided osc half period
    input  wire logic [7:0] ref_h,  // reference half period
    output logic            fm_osc, // fm vco
    output logic            am_osc, // am vco
    output logic            div_fb, // divided osc
    output logic            ref_o   // reference
);
    int cnt = 0; // shared phase, so equal periods give coincident edges

    // free running oscillators, changed just after the edge
    always @(posedge pclk)
    begin
        cnt    <= cnt + 1;
        fm_osc <= ~fm_osc;
        am_osc <= cnt[1];
        div_fb <= (cnt % (2 * div_h)) < div_h;
        ref_o  <= (cnt % (2 * ref_h)) < ref_h;
    end
    initial
    begin
        fm_osc = 0;
        am_osc = 0;
        div_fb = 0;
        ref_o  = 0;
    end
endmodule

// ### test/tpc_top_test.sv
/* self-checking bench for tpc_top: apb tasks, pump and counter tests.
   assumes the osc model drives the oscillator and reference pins. */
`timescale 1ns/1ps
`include "tpc_defs.svh"

module tpc_top_test;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, backup, halt, pin, err;
    logic        fm, am, dfb, rf, div_in, fm_en, am_en, am_lo, cp, cp_oe;
    logic [7:0]  dh, rh;
    int          n_mismatch = 0;
    int          checks = 0;

    tpc_top #(.GATE_SHORT_CYC(20), .GATE_LONG_CYC(40)) tpc_top_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .backup_mode(backup),
        .halt_mode(halt), .fm_osc_input(fm), .am_osc_input(am),
        .div_feedback(dfb), .ref_clk_in(rf), .shared_counter_input(pin),
        .divider_input(div_in), .fm_in_enable(fm_en),
        .am_in_enable(am_en), .am_low_band(am_lo),
        .charge_pump_output(cp), .charge_pump_oe(cp_oe)
    );
    tpc_osc_model tpc_osc_model_i
    (
        .pclk(pclk), .div_h(dh), .ref_h(rh), .fm_osc(fm), .am_osc(am),
        .div_fb(dfb), .ref_o(rf)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            n_mismatch++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // pin pulses eight cycles apart
    task automatic pulses(int n);
        repeat (n)
        begin
            @(posedge pclk) pin <= 1;
            repeat (4) @(posedge pclk);
            pin <= 0;
            repeat (3) @(posedge pclk);
        end
    endtask
    // poll done with a fresh status read each time, then read the count
    task automatic count_is(logic [31:0] e);
        int i;
        for (i = 0; i < 60; i++)
        begin
            apb(0, `TPC_OFF_STATUS, 0);
            if (rd[`TPC_ST_DONE] === 1'b1)
                break;
        end
        if (i == 60)
        begin
            n_mismatch++;
            report_and_stop();
        end
        apb(0, `TPC_OFF_COUNT, 0);
        chk("count", e, rd);
    endtask
    // watch the pump over 80 cycles
    task automatic pump(logic [7:0] d, logic [7:0] r, logic u, logic n);
        logic su, sd;
        su = 0; sd = 0;
        @(posedge pclk) dh <= d; rh <= r;
        // let the pump state left by the old periods wash out first
        repeat (25) @(posedge pclk);
        repeat (80)
        begin
            @(negedge pclk);
            su |= cp_oe & cp;
            sd |= cp_oe & ~cp;
        end
        chk("pump up", u, su);
        chk("pump dn", n, sd);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
        pwdata = 0; backup = 0; halt = 0; pin = 0; dh = 3; rh = 3;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, `TPC_OFF_STOP, 0);
        chk("stop rst", 1, rd);
        pump(2, 5, 0, 0);
        chk("fm en rst", 0, fm_en);
        apb(0, 12'h01C, 0);
        chk("unmapped", 1, err);
        apb(1, `TPC_OFF_STOP, 0);
        for (int s = 0; s < 4; s++)
        begin
            apb(1, `TPC_OFF_INSEL, s);
            repeat (2) @(negedge pclk);
            chk("fm en", s == 0, fm_en);
            chk("am en", s == 1 || s == 2, am_en);
            chk("am lo", s == 2, am_lo & am_en);
            chk("div in", s == 0 ? fm : s < 3 ? am : 1'b0,
                div_in);
        end
        $display("select test done");
        apb(1, `TPC_OFF_INSEL, 0);
        pump(2, 5, 1, 0);
        pump(5, 2, 0, 1);
        pump(3, 3, 0, 0);
        @(posedge pclk) backup <= 1;
        pump(2, 5, 0, 0);
        chk("fm en bk", 0, fm_en);
        @(posedge pclk) backup <= 0; halt <= 1;
        pump(5, 2, 0, 0);
        chk("fm en ht", 0, fm_en);
        @(posedge pclk) halt <= 0;
        $display("pump test done");
        apb(1, `TPC_OFF_PORTFN, 1);
        apb(1, `TPC_OFF_SETUP, 6);
        apb(1, `TPC_OFF_START, 1);
        // a valid start would show busy by now
        repeat (3) @(posedge pclk);
        apb(0, `TPC_OFF_STATUS, 0);
        chk("reserved", 0, rd[1:0]);
        apb(1, `TPC_OFF_SETUP, 3);
        apb(1, `TPC_OFF_START, 1);
        pulses(3);
        count_is(3);
        apb(1, `TPC_OFF_PORTFN, 0);
        apb(1, `TPC_OFF_SETUP, 2);
        apb(1, `TPC_OFF_START, 1);
        pulses(2);
        count_is(0);
        @(posedge pclk) pin <= 1;
        repeat (4) @(posedge pclk);
        apb(0, `TPC_OFF_STATUS, 0);
        chk("pin level", 1, rd[`TPC_ST_GPIN]);
        pin <= 0;
        $display("counter test done");
        report_and_stop();
    end
endmodule
